// >>> include/nvbac_pkg.sv
package nvbac_pkg;
  // ****************************************
  // Register map, byte-wide I/O locations
  // ****************************************
  localparam logic [1:0] ADDR_LOW_OFS = 2'h0;
  localparam logic [1:0] ADDR_HIGH_OFS = 2'h1;
  localparam logic [1:0] VALUE_OFS = 2'h2;
  localparam logic [1:0] CTRL_OFS = 2'h3;
  // ****************************************
  // Control register fields
  // ****************************************
  localparam int READ_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int ARM_BIT = 2;
  localparam int IRQ_EN_BIT = 3;
  localparam int MODE_LO_BIT = 4;
  localparam int MODE_HI_BIT = 5;
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ****************************************
  // Timing
  // ****************************************
  localparam int ADDR_W = 9;
  localparam int DEPTH = 512;
  localparam int ARM_WINDOW_CYC = 4;
  localparam int READ_STALL_CYC = 4;
  localparam int PROG_STALL_CYC = 2;
  localparam int OSC_HZ = 8000000;
  localparam int ATOMIC_TIME_US = 3400;
  localparam int SPLIT_TIME_US = 1800;
  localparam int ATOMIC_CYC = ATOMIC_TIME_US * (OSC_HZ / 1000000);
  localparam int SPLIT_CYC = SPLIT_TIME_US * (OSC_HZ / 1000000);
  typedef enum logic [1:0] {NVBAC_OP_IDLE, NVBAC_OP_READ, NVBAC_OP_PROG} nvbac_op_t;
endpackage : nvbac_pkg

// >>> include/nvbac_if.sv
`timescale 1ns/1ns
interface nvbac_if;
  logic [1:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic cpu_stall;
  logic ready_irq;
  modport device (input io_addr, input io_wdata, input io_wr, input io_rd,
    output io_rdata, output cpu_stall, output ready_irq);
  modport cpu (output io_addr, output io_wdata, output io_wr, output io_rd,
    input io_rdata, input cpu_stall, input ready_irq);
endinterface : nvbac_if

// >>> rtl/nvbac_device.sv
`timescale 1ns/1ns
// Summary of operation
// - Separate byte-wide nonvolatile space, 512 bytes
// - Read stalls CPU four cycles
// - Program start stalls CPU two cycles
// - Software loads address and data first
// - Mode 00: go within window does erase+write
// - Go bit reads set until programming done
// - No other access while programming
// - Mode 01 performs erase only
// - Mode 10 performs write only
// - Software erases before write-only mode
// - Programming timed from oscillator clock
// - Busy status pollable for completion
// - Software polls go bit before access
// - Read strobe loads addressed byte into value
// - Software keeps interrupts off during sequences
// - Registers sit in I/O space
// - Mode writes ignored while busy
// - Reset clears mode unless busy; this model clears it on every reset
// - Ready interrupt level while not busy
// - Atomic 3.4ms, split 1.8ms, mode 11 reserved
module nvbac_device #(
  parameter int ATOMIC_CYCLES = nvbac_pkg::ATOMIC_CYC,
  parameter int SPLIT_CYCLES = nvbac_pkg::SPLIT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_clk,
  nvbac_if.device bus
);
  // ****************************************
  // Storage and registers
  // ****************************************
  logic [7:0] mem_reg [nvbac_pkg::DEPTH];
  logic [8:0] nv_byte_address_reg;
  logic [7:0] nv_byte_value_reg;
  logic [1:0] program_mode_sel_reg;
  logic ready_irq_en_reg;
  logic program_go_busy_reg;
  logic [2:0] arm_cnt_reg;
  logic [2:0] stall_cnt_reg;
  logic [7:0] rdata_reg;
  logic [22:0] prog_cnt_reg;
  logic [1:0] prog_mode_reg;
  logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic osc_lvl_reg, osc_lvl_d_reg;
  logic osc_tick;
  logic ctrl_wr, go_req, prog_done;

  function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
    hit = bus.io_wr && (a == ofs);
  endfunction : hit

  assign ctrl_wr = hit(bus.io_addr, nvbac_pkg::CTRL_OFS);
  // Go only counts inside the arm window; mode 11 is reserved, so refused
  assign go_req = ctrl_wr && bus.io_wdata[nvbac_pkg::GO_BIT] && (arm_cnt_reg != 3'h0)
    && !program_go_busy_reg && (program_mode_sel_reg != 2'h3);
  // Oscillator sampled through three flops; edge when second and third agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      osc_lvl_reg <= 1'b0;
      osc_lvl_d_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_clk;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      if (osc_s2_reg == osc_s3_reg) begin
        osc_lvl_reg <= osc_s3_reg;
      end
      osc_lvl_d_reg <= osc_lvl_reg;
    end
  end
  assign osc_tick = osc_lvl_reg && !osc_lvl_d_reg;
  assign prog_done = program_go_busy_reg && osc_tick && (prog_cnt_reg == 23'h000001);

  // ****************************************
  // Address and value registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_byte_address_reg <= nvbac_pkg::ADDR_RESET;
    end else if (!program_go_busy_reg) begin
      if (hit(bus.io_addr, nvbac_pkg::ADDR_LOW_OFS)) begin
        nv_byte_address_reg[7:0] <= bus.io_wdata;
      end else if (hit(bus.io_addr, nvbac_pkg::ADDR_HIGH_OFS)) begin
        nv_byte_address_reg[8] <= bus.io_wdata[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_byte_value_reg <= nvbac_pkg::VALUE_RESET;
    end else if (ctrl_wr && bus.io_wdata[nvbac_pkg::READ_BIT] && !program_go_busy_reg) begin
      nv_byte_value_reg <= mem_reg[nv_byte_address_reg];
    end else if (hit(bus.io_addr, nvbac_pkg::VALUE_OFS) && !program_go_busy_reg) begin
      nv_byte_value_reg <= bus.io_wdata;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Reset is only seen as busy==0 in this model, so mode clears to 00
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_mode_sel_reg <= nvbac_pkg::MODE_RESET;
      ready_irq_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ready_irq_en_reg <= bus.io_wdata[nvbac_pkg::IRQ_EN_BIT];
      if (!program_go_busy_reg) begin
        program_mode_sel_reg <= bus.io_wdata[nvbac_pkg::MODE_HI_BIT:nvbac_pkg::MODE_LO_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_cnt_reg <= 3'h0;
    end else if (ctrl_wr && bus.io_wdata[nvbac_pkg::ARM_BIT] && !program_go_busy_reg) begin
      arm_cnt_reg <= 3'(nvbac_pkg::ARM_WINDOW_CYC);
    end else if (arm_cnt_reg != 3'h0) begin
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
    end
  end

  // ****************************************
  // Programming engine
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_go_busy_reg <= 1'b0;
      prog_cnt_reg <= 23'h000000;
      prog_mode_reg <= nvbac_pkg::MODE_ATOMIC;
    end else if (go_req) begin
      program_go_busy_reg <= 1'b1;
      prog_mode_reg <= program_mode_sel_reg;
      prog_cnt_reg <= (program_mode_sel_reg == nvbac_pkg::MODE_ATOMIC) ?
        23'(ATOMIC_CYCLES) : 23'(SPLIT_CYCLES);
    end else if (prog_done) begin
      program_go_busy_reg <= 1'b0;
    end else if (program_go_busy_reg && osc_tick) begin
      prog_cnt_reg <= prog_cnt_reg - 23'h000001;
    end
  end

  // Cell updated at completion; write-only ANDs into the old content
  always_ff @(posedge clk) begin
    if (prog_done) begin
      case (prog_mode_reg)
        nvbac_pkg::MODE_ERASE: mem_reg[nv_byte_address_reg] <= nvbac_pkg::ERASED_BYTE;
        nvbac_pkg::MODE_WRITE:
          mem_reg[nv_byte_address_reg] <= mem_reg[nv_byte_address_reg] & nv_byte_value_reg;
        default: mem_reg[nv_byte_address_reg] <= nv_byte_value_reg;
      endcase
    end
  end

  // ****************************************
  // CPU stall and read port
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_reg <= 3'h0;
    end else if (ctrl_wr && bus.io_wdata[nvbac_pkg::READ_BIT] && !program_go_busy_reg) begin
      stall_cnt_reg <= 3'(nvbac_pkg::READ_STALL_CYC);
    end else if (go_req) begin
      stall_cnt_reg <= 3'(nvbac_pkg::PROG_STALL_CYC);
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_reg <= stall_cnt_reg - 3'h1;
    end
  end
  assign bus.cpu_stall = (stall_cnt_reg != 3'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (bus.io_rd) begin
      if (bus.io_addr == nvbac_pkg::ADDR_LOW_OFS) begin
        rdata_reg <= nv_byte_address_reg[7:0];
      end else if (bus.io_addr == nvbac_pkg::ADDR_HIGH_OFS) begin
        rdata_reg <= {7'h00, nv_byte_address_reg[8]};
      end else if (bus.io_addr == nvbac_pkg::VALUE_OFS) begin
        rdata_reg <= nv_byte_value_reg;
      end else begin
        rdata_reg <= {2'h0, program_mode_sel_reg, ready_irq_en_reg,
          (arm_cnt_reg != 3'h0), program_go_busy_reg, 1'b0};
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign bus.io_rdata = rdata_reg;
  assign bus.ready_irq = ready_irq_en_reg && !program_go_busy_reg;
endmodule : nvbac_device

// >>> rtl/nvbac_cpu.sv
`timescale 1ns/1ns
// ****************************************
// Command-driven access sequencer
// ****************************************
module nvbac_cpu (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [1:0] cmd_mode,
  input wire logic [8:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  nvbac_if.cpu bus
);
  typedef enum logic [3:0] {
    NVBAC_POLL, NVBAC_POLL_WAIT, NVBAC_IDLE, NVBAC_MODE, NVBAC_AH, NVBAC_AL,
    NVBAC_VAL, NVBAC_ARM, NVBAC_GO, NVBAC_RD, NVBAC_RDV, NVBAC_RDW
  } nvbac_cstate_t;
  nvbac_cstate_t state_reg;
  logic rd_reg;
  logic [1:0] mode_reg;
  logic [8:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] rsp_data_reg;
  logic rsp_valid_reg;
  logic gap_reg;

  assign cmd_ready = (state_reg == NVBAC_IDLE);
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= NVBAC_POLL;
      rd_reg <= 1'b0;
      mode_reg <= 2'h0;
      addr_reg <= 9'h000;
      data_reg <= 8'h00;
      rsp_data_reg <= 8'h00;
      rsp_valid_reg <= 1'b0;
      gap_reg <= 1'b0;
      bus.io_addr <= 2'h0;
      bus.io_wdata <= 8'h00;
      bus.io_wr <= 1'b0;
      bus.io_rd <= 1'b0;
    end else begin
      bus.io_wr <= 1'b0;
      bus.io_rd <= 1'b0;
      rsp_valid_reg <= 1'b0;
      gap_reg <= 1'b0;
      // Stall shows a cycle after its strobe, read data a cycle after the read
      if (!bus.cpu_stall && !gap_reg) begin
        case (state_reg)
          NVBAC_POLL: begin
            bus.io_rd <= 1'b1;
            bus.io_addr <= nvbac_pkg::CTRL_OFS;
            gap_reg <= 1'b1;
            state_reg <= NVBAC_POLL_WAIT;
          end
          NVBAC_POLL_WAIT: begin
            state_reg <= bus.io_rdata[nvbac_pkg::GO_BIT] ? NVBAC_POLL : NVBAC_IDLE;
          end
          NVBAC_IDLE: begin
            if (cmd_valid) begin
              rd_reg <= cmd_read;
              mode_reg <= cmd_mode;
              addr_reg <= cmd_addr;
              data_reg <= cmd_data;
              state_reg <= NVBAC_MODE;
            end
          end
          NVBAC_MODE: begin
            bus.io_wr <= 1'b1;
            bus.io_addr <= nvbac_pkg::CTRL_OFS;
            // Ready request kept enabled so its level is visible
            bus.io_wdata <= {2'h0, mode_reg, 4'h8};
            state_reg <= NVBAC_AH;
          end
          NVBAC_AH: begin
            bus.io_wr <= 1'b1;
            bus.io_addr <= nvbac_pkg::ADDR_HIGH_OFS;
            bus.io_wdata <= {7'h00, addr_reg[8]};
            state_reg <= NVBAC_AL;
          end
          NVBAC_AL: begin
            bus.io_wr <= 1'b1;
            bus.io_addr <= nvbac_pkg::ADDR_LOW_OFS;
            bus.io_wdata <= addr_reg[7:0];
            state_reg <= rd_reg ? NVBAC_RD : NVBAC_VAL;
          end
          NVBAC_VAL: begin
            bus.io_wr <= 1'b1;
            bus.io_addr <= nvbac_pkg::VALUE_OFS;
            bus.io_wdata <= data_reg;
            state_reg <= NVBAC_ARM;
          end
          NVBAC_ARM: begin
            bus.io_wr <= 1'b1;
            bus.io_addr <= nvbac_pkg::CTRL_OFS;
            bus.io_wdata <= {2'h0, mode_reg, 4'hc};
            state_reg <= NVBAC_GO;
          end
          NVBAC_GO: begin
            bus.io_wr <= 1'b1;
            bus.io_addr <= nvbac_pkg::CTRL_OFS;
            bus.io_wdata <= {2'h0, mode_reg, 4'ha};
            gap_reg <= 1'b1;
            state_reg <= NVBAC_POLL;
          end
          NVBAC_RD: begin
            bus.io_wr <= 1'b1;
            bus.io_addr <= nvbac_pkg::CTRL_OFS;
            bus.io_wdata <= {2'h0, mode_reg, 4'h9};
            gap_reg <= 1'b1;
            state_reg <= NVBAC_RDV;
          end
          NVBAC_RDV: begin
            bus.io_rd <= 1'b1;
            bus.io_addr <= nvbac_pkg::VALUE_OFS;
            gap_reg <= 1'b1;
            state_reg <= NVBAC_RDW;
          end
          default: begin
            rsp_data_reg <= bus.io_rdata;
            rsp_valid_reg <= 1'b1;
            state_reg <= NVBAC_POLL;
          end
        endcase
      end
    end
  end
endmodule : nvbac_cpu

// >>> bench/nvbac_props.sv
`timescale 1ns/1ns
// ****
// Interface checker
// ****
module nvbac_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_stall,
  input wire logic ready_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  logic ctrl_rd;
  logic go_wr;
  assign ctrl_wr = io_wr && io_addr == nvbac_pkg::CTRL_OFS;
  assign ctrl_rd = io_rd && io_addr == nvbac_pkg::CTRL_OFS;
  // Mode 11 excluded: that go is refused and must not stall
  assign go_wr = ctrl_wr && io_wdata[nvbac_pkg::GO_BIT]
    && io_wdata[nvbac_pkg::MODE_HI_BIT:nvbac_pkg::MODE_LO_BIT] != 2'h3;
  AST_READ_STALL: assert property (
    ctrl_wr && io_wdata[nvbac_pkg::READ_BIT] |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall not four cycles");
  AST_PROG_STALL: assert property (
    go_wr && $past(ctrl_wr && io_wdata[nvbac_pkg::ARM_BIT]) |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("program stall not two cycles");
  AST_STALL_END: assert property (cpu_stall[*4] |=> !cpu_stall)
    else $error("stall longer than four cycles");
  AST_STALL_CAUSE: assert property ($rose(cpu_stall) |-> $past(ctrl_wr))
    else $error("stall without control write");
  AST_RDATA_IDLE: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
    else $error("read data outside read answer");
  AST_CTRL_RES: assert property (
    $past(ctrl_rd) |-> !io_rdata[nvbac_pkg::READ_BIT] && io_rdata[7:6] == 2'h0)
    else $error("control reserved bits not zero");
  AST_BUSY_IRQ: assert property (
    $past(ctrl_rd) && io_rdata[nvbac_pkg::GO_BIT] |-> !$past(ready_irq))
    else $error("ready request while busy");
  AST_GO_IRQ: assert property (
    go_wr && $past(ctrl_wr && io_wdata[nvbac_pkg::ARM_BIT]) |=> !ready_irq [*2])
    else $error("ready request after program start");
endmodule : nvbac_checker

// >>> bench/nvbac_tb_top.sv
`timescale 1ns/1ns
module nvbac_tb_top;
  // Short counts keep the run small; oscillator period is four clocks
  localparam int ATOM = 30;
  localparam int SPLT = 10;
  logic clk, rst_n, osc_clk, cmd_valid, cmd_ready, cmd_read, rsp_valid;
  logic [1:0] cmd_mode;
  logic [8:0] cmd_addr;
  logic [7:0] cmd_data, rsp_data, got;
  int fails = 0, samples_checked = 0, cyc = 0, t0 = 0;
  nvbac_if bus_if ();
  nvbac_device #(.ATOMIC_CYCLES(ATOM), .SPLIT_CYCLES(SPLT)) nvbac_device_inst (.clk(clk),
    .rst_n(rst_n), .osc_clk(osc_clk), .bus(bus_if));
  nvbac_cpu nvbac_cpu_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_mode(cmd_mode), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(bus_if));
  nvbac_checker nvbac_checker_inst (.clk(clk), .rst_n(rst_n), .io_addr(bus_if.io_addr),
    .io_wdata(bus_if.io_wdata), .io_wr(bus_if.io_wr), .io_rd(bus_if.io_rd),
    .io_rdata(bus_if.io_rdata), .cpu_stall(bus_if.cpu_stall), .ready_irq(bus_if.ready_irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Phase offset keeps oscillator unrelated to clk
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #20 osc_clk = ~osc_clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic finish_test();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic issue(input logic rd, input logic [1:0] md, input logic [8:0] a,
    input logic [7:0] d);
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_mode <= md;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b0;
    t0 = cyc;
  endtask : issue
  task automatic rd_byte(input logic [8:0] a, output logic [7:0] v);
    issue(1'b1, 2'h0, a, 8'h00);
    do @(posedge clk); while (rsp_valid !== 1'b1);
    v = rsp_data;
  endtask : rd_byte
  // ****
  // Scenarios
  // ****
  task automatic test_atomic();
    int tp;
    issue(1'b0, nvbac_pkg::MODE_ATOMIC, 9'h1ff, 8'ha5);
    tp = t0;
    repeat (20) @(posedge clk);
    chk("irq while busy", 0, bus_if.ready_irq);
    rd_byte(9'h1ff, got);
    chk("atomic data", 8'ha5, got);
    chk("irq when ready", 1, bus_if.ready_irq);
    chk("atomic busy span", 1, (cyc - tp) >= (ATOM - 1) * 4);
    $display("test_atomic done");
  endtask : test_atomic
  task automatic test_split();
    int tp;
    issue(1'b0, nvbac_pkg::MODE_ERASE, 9'h1ff, 8'h00);
    tp = t0;
    rd_byte(9'h1ff, got);
    chk("erase data", nvbac_pkg::ERASED_BYTE, got);
    chk("erase min span", 1, (cyc - tp) >= (SPLT - 1) * 4);
    chk("erase max span", 1, (cyc - tp) < (ATOM - 1) * 4);
    issue(1'b0, nvbac_pkg::MODE_WRITE, 9'h1ff, 8'h3c);
    rd_byte(9'h1ff, got);
    chk("write only data", 8'h3c, got);
    $display("test_split done");
  endtask : test_split
  // Write-only on a cell not erased leaves only common ones
  task automatic test_unerased();
    issue(1'b0, nvbac_pkg::MODE_ATOMIC, 9'h000, 8'hf0);
    issue(1'b0, nvbac_pkg::MODE_ATOMIC, 9'h100, 8'h0f);
    issue(1'b0, nvbac_pkg::MODE_WRITE, 9'h000, 8'h3c);
    rd_byte(9'h000, got);
    chk("unerased data", 8'h30, got);
    rd_byte(9'h100, got);
    chk("high half data", 8'h0f, got);
    rd_byte(9'h1ff, got);
    chk("other byte kept", 8'h3c, got);
    $display("test_unerased done");
  endtask : test_unerased
  task automatic test_reserved();
    issue(1'b0, 2'h3, 9'h1ff, 8'h00);
    rd_byte(9'h1ff, got);
    chk("reserved mode data", 8'h3c, got);
    $display("test_reserved done");
  endtask : test_reserved
  // Reset in mid-run clears mode and enable, never the stored bytes
  task automatic test_reset();
    logic [1:0] md;
    issue(1'b0, 2'h3, 9'h1ff, 8'h00);
    do @(posedge clk); while (cmd_ready !== 1'b1);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq in reset", 0, bus_if.ready_irq);
    rst_n <= 1'b1;
    do @(posedge clk); while (bus_if.io_rd !== 1'b1);
    @(posedge clk);
    md = bus_if.io_rdata[nvbac_pkg::MODE_HI_BIT:nvbac_pkg::MODE_LO_BIT];
    chk("mode after reset", nvbac_pkg::MODE_RESET, md);
    rd_byte(9'h1ff, got);
    chk("kept over reset", 8'h3c, got);
    $display("test_reset done");
  endtask : test_reset
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_mode = 2'h0;
    cmd_addr = 9'h000;
    cmd_data = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_atomic();
    test_split();
    test_unerased();
    test_reserved();
    test_reset();
    finish_test();
  end
endmodule : nvbac_tb_top
